/* pmtl_top.sv */
// Protection master trip logic with APB registers and peer link supervision.
`timescale 1ns/10ps
`default_nettype none
module pmtl_top #(
    parameter int N = pmtl_pkg::NELEM,
    parameter longint DAY_CYCLES = pmtl_pkg::DAY_CYC
) (
    input wire logic i_mclk,                     // 10 MHz clock
    input wire logic i_rst,                      // Async reset, high
    input wire logic i_psel,                     // APB select
    input wire logic i_penable,                  // APB enable
    input wire logic i_pwrite,                   // APB write
    input wire logic [7:0] i_paddr,              // APB byte address
    input wire logic [31:0] i_pwdata,            // APB write data
    output logic [31:0] o_prdata,                // APB read data
    output logic o_pready,                       // APB ready
    output logic o_pslverr,                      // APB error
    input wire logic [N-1:0] i_fault,            // Element fault detect (pins)
    input wire logic [N-1:0] i_fault_l1,         // Element fault on phase one
    input wire logic [N-1:0] i_fault_l2,         // Element fault on phase two
    input wire logic [N-1:0] i_fault_l3,         // Element fault on phase three
    input wire logic i_external_block_input_one, // Protection block one
    input wire logic i_external_block_input_two, // Protection block two
    input wire logic i_external_trip_block_input, // Trip command block
    input wire logic i_link_err,                 // Link error event (pin)
    input wire logic [7:0] i_peer_pairing_code,  // Peer pairing code
    output logic [N-1:0] o_element_alarm,        // Element alarms
    output logic [N-1:0] o_element_trip,         // Element trips
    output logic [N-1:0] o_element_trip_command, // Element trip commands
    output logic o_general_alarm,                // General alarm
    output logic o_general_trip,                 // General trip
    output logic [2:0] o_phase_collective_alarm, // Per-phase alarms
    output logic [2:0] o_phase_collective_trip,  // Per-phase trips
    output logic o_link_active,                  // Peer link working
    output logic o_remote_access,                // Remote access granted
    output logic o_link_quality_warning,         // Daily error warning
    output logic o_irq                           // Interrupt
);
    import pmtl_pkg::*;

    // The element carrier structs are sized by the package, so N must match them.
    if (N != NELEM || DAY_CYCLES < 1) begin : g_bad_param
        $error("pmtl_top: N must equal NELEM and DAY_CYCLES must be positive");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SW = 4 * N + 4 + 8;
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic [N-1:0] flt;
    logic [N-1:0] f1;
    logic [N-1:0] f2;
    logic [N-1:0] f3;
    logic eb1;
    logic eb2;
    logic etb;
    logic lerr;
    logic [7:0] peer_code;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {i_fault, i_fault_l1, i_fault_l2, i_fault_l3, i_external_block_input_one,
                         i_external_block_input_two, i_external_trip_block_input, i_link_err,
                         i_peer_pairing_code};
            sync2_ff <= sync1_ff;
        end
    end
    assign {flt, f1, f2, f3, eb1, eb2, etb, lerr, peer_code} = sync2_ff;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0] ctrl_ff;
    logic [5:0] nxt_ctrl;
    logic [N-1:0] supv_ff;
    logic [N-1:0] nxt_supv;
    logic [N-1:0] phcap_ff;
    logic [N-1:0] nxt_phcap;
    logic [7:0] pair_ff;
    logic [7:0] nxt_pair;
    logic [15:0] errmax_ff;
    logic [15:0] nxt_errmax;
    logic [NIRQ-1:0] irq_st_ff;
    logic [NIRQ-1:0] nxt_irq_st;
    logic [NIRQ-1:0] irq_mask_ff;
    logic [NIRQ-1:0] nxt_irq_mask;
    logic [DLYW-1:0] dly_ff [N];
    logic [DLYW-1:0] nxt_dly [N];
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [NIRQ-1:0] irq_evt;
    logic [31:0] status_word;
    logic [15:0] errcnt_ff;

    function automatic logic addr_ok(input logic [7:0] a, input int n);
        logic r;
        r = (a <= ADDR_PEER) || (a >= ADDR_DLY0 && a < ADDR_DLY0 + 8'(4 * n));
        return r && (a[1:0] == 2'b00);
    endfunction

    wire apb_acc = i_psel && i_penable && !pready_ff;
    wire wr = apb_acc && i_pwrite && addr_ok(i_paddr, N);
    wire rd = apb_acc && !i_pwrite && addr_ok(i_paddr, N);

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_supv = supv_ff;
        nxt_phcap = phcap_ff;
        nxt_pair = pair_ff;
        nxt_errmax = errmax_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_dly = dly_ff;
        nxt_pready = apb_acc;
        nxt_pslverr = apb_acc && !addr_ok(i_paddr, N);
        nxt_prdata = '0;
        if (wr) begin
            unique case (i_paddr)
                ADDR_CTRL: nxt_ctrl = i_pwdata[5:0];
                ADDR_SUPV: nxt_supv = i_pwdata[N-1:0];
                ADDR_PHCAP: nxt_phcap = i_pwdata[N-1:0];
                ADDR_PAIR: nxt_pair = i_pwdata[7:0];
                ADDR_ERRMAX: nxt_errmax = i_pwdata[15:0];
                ADDR_IRQ_MASK: nxt_irq_mask = i_pwdata[NIRQ-1:0];
                default: begin
                    for (int k = 0; k < N; k++) begin
                        if (i_paddr == ADDR_DLY0 + 8'(4 * k)) begin
                            nxt_dly[k] = i_pwdata[DLYW-1:0];
                        end
                    end
                end
            endcase
        end
        if (rd) begin
            unique case (i_paddr)
                ADDR_CTRL: nxt_prdata = 32'(ctrl_ff);
                ADDR_SUPV: nxt_prdata = 32'(supv_ff);
                ADDR_PHCAP: nxt_prdata = 32'(phcap_ff);
                ADDR_PAIR: nxt_prdata = 32'(pair_ff);
                ADDR_ERRMAX: nxt_prdata = 32'(errmax_ff);
                ADDR_STATUS: nxt_prdata = status_word;
                ADDR_IRQ_ST: nxt_prdata = 32'(irq_st_ff);
                ADDR_IRQ_MASK: nxt_prdata = 32'(irq_mask_ff);
                ADDR_ERRCNT: nxt_prdata = 32'(errcnt_ff);
                ADDR_PEER: nxt_prdata = 32'(peer_code);
                default: begin
                    for (int k = 0; k < N; k++) begin
                        if (i_paddr == ADDR_DLY0 + 8'(4 * k)) begin
                            nxt_prdata = 32'(dly_ff[k]);
                        end
                    end
                end
            endcase
        end
        // A read clears the status, but an event in the same cycle still sets.
        nxt_irq_st = ((rd && i_paddr == ADDR_IRQ_ST) ? '0 : irq_st_ff) | irq_evt;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_ff <= CTRL_RST;
            supv_ff <= '0;
            phcap_ff <= '0;
            pair_ff <= PAIR_RST;
            errmax_ff <= ERRMAX_RST;
            irq_st_ff <= '0;
            irq_mask_ff <= '0;
            for (int k = 0; k < N; k++) begin
                dly_ff[k] <= DLY_RST;
            end
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            supv_ff <= nxt_supv;
            phcap_ff <= nxt_phcap;
            pair_ff <= nxt_pair;
            errmax_ff <= nxt_errmax;
            irq_st_ff <= nxt_irq_st;
            irq_mask_ff <= nxt_irq_mask;
            dly_ff <= nxt_dly;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Blocking
    // ------------------------------------------------------------
    wire ext_blk = ctrl_ff[CTRL_EXT_BLK_EN] && (eb1 || eb2);
    wire prot_off = !ctrl_ff[CTRL_PROT_EN] || ext_blk;
    wire tcmd_blk = ctrl_ff[CTRL_PERM_TCB] || (ctrl_ff[CTRL_EXT_TCB_EN] && etb);

    // ------------------------------------------------------------
    // Protective elements
    // ------------------------------------------------------------
    logic [DLYW-1:0] tmr_ff [N];
    logic [DLYW-1:0] nxt_tmr [N];
    logic [N-1:0] trip_ff;
    logic [N-1:0] nxt_trip;
    pmtl_elem_s el_ff;
    pmtl_elem_s nxt_el;
    pmtl_phase_s ph_ff;
    pmtl_phase_s nxt_ph;
    logic gen_alarm_ff;
    logic gen_trip_ff;
    logic [N-1:0] alarm_c;
    logic [N-1:0] contrib;
    logic [N-1:0] phase_src;

    always_comb begin
        alarm_c = prot_off ? '0 : flt;
        contrib = ~supv_ff;
        phase_src = contrib & phcap_ff;
        nxt_tmr = tmr_ff;
        nxt_trip = '0;
        for (int k = 0; k < N; k++) begin
            if (!alarm_c[k]) begin
                nxt_tmr[k] = '0;
            end else if (tmr_ff[k] < dly_ff[k]) begin
                nxt_tmr[k] = tmr_ff[k] + 1'b1;
            end
            // Trip only once the delay has run with the fault still present.
            nxt_trip[k] = alarm_c[k] && (tmr_ff[k] >= dly_ff[k]);
        end
        nxt_el.alarm = alarm_c;
        nxt_el.trip = nxt_trip;
        nxt_el.trip_cmd = '0;
        // Collectives decode the same next values, so they change in the same cycle.
        nxt_ph.alarm = {|(alarm_c & phase_src & f3), |(alarm_c & phase_src & f2),
                        |(alarm_c & phase_src & f1)};
        nxt_ph.trip = {|(nxt_trip & phase_src & f3), |(nxt_trip & phase_src & f2),
                       |(nxt_trip & phase_src & f1)};
        if (|(nxt_trip & contrib) && !tcmd_blk) begin
            nxt_el.trip_cmd = nxt_trip & contrib;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < N; k++) begin
                tmr_ff[k] <= '0;
            end
            el_ff <= '0;
            ph_ff <= '0;
            gen_alarm_ff <= 1'b0;
            gen_trip_ff <= 1'b0;
        end else begin
            tmr_ff <= nxt_tmr;
            el_ff <= nxt_el;
            ph_ff <= nxt_ph;
            gen_alarm_ff <= |(nxt_el.alarm & contrib);
            gen_trip_ff <= |(nxt_trip & contrib);
        end
    end

    // ------------------------------------------------------------
    // Peer protection link supervision
    // ------------------------------------------------------------
    logic [63:0] day_ff;
    logic [63:0] nxt_day;
    logic [15:0] nxt_errcnt;
    logic warn_ff;
    logic nxt_warn;
    logic link_ff;
    logic lerr_d_ff;
    wire link_en = ctrl_ff[CTRL_LINK_EN];
    wire pair_ok = (peer_code == pair_ff);
    wire err_evt = link_en && lerr && !lerr_d_ff;

    always_comb begin
        nxt_day = day_ff + 64'd1;
        nxt_errcnt = errcnt_ff;
        nxt_warn = warn_ff;
        if (!link_en) begin
            nxt_day = '0;
            nxt_errcnt = '0;
            nxt_warn = 1'b0;
        end else if (day_ff >= 64'(DAY_CYCLES - 1)) begin
            nxt_day = '0;
            nxt_errcnt = '0;
            nxt_warn = 1'b0;
        end else if (err_evt && errcnt_ff != 16'hffff) begin
            nxt_errcnt = errcnt_ff + 16'd1;
        end
        if (nxt_errcnt > errmax_ff) begin
            nxt_warn = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            day_ff <= '0;
            errcnt_ff <= '0;
            warn_ff <= 1'b0;
            link_ff <= 1'b0;
            lerr_d_ff <= 1'b0;
        end else begin
            day_ff <= nxt_day;
            errcnt_ff <= nxt_errcnt;
            warn_ff <= nxt_warn;
            link_ff <= link_en && pair_ok;
            lerr_d_ff <= lerr;
        end
    end

    // ------------------------------------------------------------
    // Status and interrupt
    // ------------------------------------------------------------
    assign irq_evt = {link_en && !pair_ok, nxt_warn && !warn_ff,
                      |(nxt_trip & contrib) && !gen_trip_ff,
                      |(nxt_el.alarm & contrib) && !gen_alarm_ff};
    assign status_word = {26'h0, tcmd_blk, prot_off, warn_ff, link_ff, gen_trip_ff, gen_alarm_ff};

    logic irq_ff;
    logic remote_ff;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_ff <= 1'b0;
            remote_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_irq_st & irq_mask_ff);
            remote_ff <= ctrl_ff[CTRL_REMOTE_OK] && link_en && pair_ok;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_element_alarm = el_ff.alarm;
    assign o_element_trip = el_ff.trip;
    assign o_element_trip_command = el_ff.trip_cmd;
    assign o_general_alarm = gen_alarm_ff;
    assign o_general_trip = gen_trip_ff;
    assign o_phase_collective_alarm = ph_ff.alarm;
    assign o_phase_collective_trip = ph_ff.trip;
    assign o_link_active = link_ff;
    assign o_remote_access = remote_ff;
    assign o_link_quality_warning = warn_ff;
    assign o_irq = irq_ff;

endmodule
`default_nettype wire

/* pmtl_pkg.sv */
// Package of constants, register map and carrier types for the protection master trip logic.
// Functional notes
// - Protection inactive or master blocked: no element alarm, trip or trip command takes effect.
// - External block enabled: either block input asserted blocks all protection until both drop.
// - Permanent trip-command block suppresses all trip commands; alarms and trips continue.
// - External trip block enabled: trip commands suppressed while its input stays asserted.
// - Each element raises its alarm as soon as it sees its fault.
// - Element delay timer starts on alarm; trip only if fault persists at expiry.
// - General alarm is the OR of all contributing element alarms.
// - General trip is the OR of all contributing element trips.
// - Element trip command when general trip present and its command is unblocked.
// - Supervision-only elements have no trip command and never contribute one.
// - Phase collectives fed only by single-phase capable, non-supervision elements.
// - Each phase collective alarm is the OR of element alarms on that phase.
// - Each phase collective trip is the OR of element trips on that phase.
// - Count link transmission errors over 24 hours; warn when count exceeds maximum.
// - Peer pairing code must match; a mismatched peer gets no working connection.
// - Remote configuration access granted by default, denied when permission inactive; code also needs link enabled and code matched, link off at reset.
// - Protection link operates only while its enable setting is active.
package pmtl_pkg;

    localparam int NELEM = 4;
    localparam int DLYW = 16;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SUPV = 8'h04;
    localparam logic [7:0] ADDR_PHCAP = 8'h08;
    localparam logic [7:0] ADDR_PAIR = 8'h0c;
    localparam logic [7:0] ADDR_ERRMAX = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
    localparam logic [7:0] ADDR_ERRCNT = 8'h20;
    localparam logic [7:0] ADDR_PEER = 8'h24;
    localparam logic [7:0] ADDR_DLY0 = 8'h40;

    // Control register bit positions.
    localparam int CTRL_PROT_EN = 0;
    localparam int CTRL_EXT_BLK_EN = 1;
    localparam int CTRL_PERM_TCB = 2;
    localparam int CTRL_EXT_TCB_EN = 3;
    localparam int CTRL_LINK_EN = 4;
    localparam int CTRL_REMOTE_OK = 5;

    // Control reset: protection active, remote access permitted.
    localparam logic [5:0] CTRL_RST = 6'h21;
    localparam logic [7:0] PAIR_RST = 8'h00;
    localparam logic [15:0] ERRMAX_RST = 16'h000a;
    localparam logic [DLYW-1:0] DLY_RST = 16'h0064;

    // Interrupt status bits.
    localparam int IRQ_GEN_ALARM = 0;
    localparam int IRQ_GEN_TRIP = 1;
    localparam int IRQ_QUAL_WARN = 2;
    localparam int IRQ_PAIR_BAD = 3;
    localparam int NIRQ = 4;

    // Error counting window.
    localparam longint DAY_S = 64'd86400;
    localparam longint CLK_HZ = 64'd10000000;
    localparam longint DAY_CYC = DAY_S * CLK_HZ;

    typedef struct packed {
        logic [NELEM-1:0] alarm;
        logic [NELEM-1:0] trip;
        logic [NELEM-1:0] trip_cmd;
    } pmtl_elem_s;

    typedef struct packed {
        logic [2:0] alarm;
        logic [2:0] trip;
    } pmtl_phase_s;

endpackage

/* pmtl_chk.sv */
// Port-level assertion checker for the protection master trip logic.
`timescale 1ns/10ps
`default_nettype none
module pmtl_chk #(
    parameter int N = 4
) (
    input wire logic i_mclk, // Clock
    input wire logic i_rst, // Reset
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic o_pready, // APB ready
    input wire logic o_pslverr, // APB error
    input wire logic [N-1:0] i_fault, // Element faults
    input wire logic [N-1:0] o_element_alarm, // Element alarms
    input wire logic [N-1:0] o_element_trip, // Element trips
    input wire logic [N-1:0] o_element_trip_command, // Trip commands
    input wire logic o_general_alarm, // General alarm
    input wire logic o_general_trip, // General trip
    input wire logic [2:0] o_phase_collective_alarm, // Phase alarms
    input wire logic [2:0] o_phase_collective_trip, // Phase trips
    input wire logic o_link_active, // Link working
    input wire logic o_remote_access // Remote access
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    sequence s_access;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_answer;
        o_pready ##1 !o_pready;
    endsequence
    property p_apb_answer;
        s_access |=> s_answer;
    endproperty
    property p_err_ready;
        o_pslverr |-> o_pready;
    endproperty
    property p_gen_alarm;
        o_general_alarm |-> (|o_element_alarm);
    endproperty
    property p_gen_trip;
        o_general_trip |-> (|o_element_trip);
    endproperty
    property p_phase_alarm;
        (|o_phase_collective_alarm) |-> o_general_alarm;
    endproperty
    property p_phase_trip;
        (|o_phase_collective_trip) |-> o_general_trip;
    endproperty
    property p_cmd;
        (|o_element_trip_command) |->
            o_general_trip && ((o_element_trip_command & ~o_element_trip) == '0);
    endproperty
    property p_trip_alarm;
        (o_element_trip & ~o_element_alarm) == '0;
    endproperty
    property p_alarm_cause;
        $rose(o_element_alarm[0]) |->
            ($past(i_fault[0], 2) || $past(i_fault[0], 3) || $past(i_fault[0], 4));
    endproperty
    property p_remote;
        o_remote_access |-> o_link_active;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one cycle");
    a_err_ready: assert property (p_err_ready) else $error("slave error without ready");
    a_gen_alarm: assert property (p_gen_alarm) else $error("general alarm without cause");
    a_gen_trip: assert property (p_gen_trip) else $error("general trip without cause");
    a_phase_alarm: assert property (p_phase_alarm) else $error("phase alarm alone");
    a_phase_trip: assert property (p_phase_trip) else $error("phase trip alone");
    a_cmd: assert property (p_cmd) else $error("trip command without trip");
    a_trip_alarm: assert property (p_trip_alarm) else $error("trip without alarm");
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without fault");
    a_remote: assert property (p_remote) else $error("remote access without link");
endmodule
bind pmtl_top pmtl_chk #(.N(N)) u_chk (.i_mclk, .i_rst, .i_psel, .i_penable, .o_pready,
    .o_pslverr, .i_fault, .o_element_alarm, .o_element_trip, .o_element_trip_command,
    .o_general_alarm, .o_general_trip, .o_phase_collective_alarm, .o_phase_collective_trip,
    .o_link_active, .o_remote_access);
`default_nettype wire

/* pmtl_peer.sv */
// Model of the peer relay at the far end of the protection link.
`timescale 1ns/10ps
`default_nettype none
module pmtl_peer (
    input wire logic i_mclk, // Clock
    input wire logic i_rst, // Reset
    input wire logic [7:0] i_code, // Peer pairing code
    input wire logic i_en, // Peer link enabled
    input wire logic i_swap, // Wrong fibre patched
    input wire logic i_noisy, // Corrupted frames
    output logic [7:0] o_code, // Code seen by device
    output logic o_err // Error event line
);
    logic [7:0] cnt_ff;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= 8'h00;
            o_err <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
            o_err <= i_noisy & ~o_err;
        end
    end
    // Without traffic the code line carries nothing stable.
    always_comb begin
        if (!i_en) o_code = cnt_ff;
        else if (i_swap) o_code = ~i_code;
        else o_code = i_code;
    end
endmodule
`default_nettype wire

/* pmtl_top_bench.sv */
// Self-checking bench for the protection master trip logic.
`timescale 1ns/10ps
`default_nettype none
module pmtl_top_bench;
    import pmtl_pkg::*;
    localparam int DAY = 20000;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00, code = 8'h5a, pcode;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, serr, perr, ga, gt, la, ra, qw, irq;
    logic [3:0] flt = 4'h0, l1 = 4'h0, l2 = 4'h0, l3 = 4'h0, ea, et, ec;
    logic [3:0] supv = 4'h8, phc = 4'h3;
    logic blk1 = 1'b0, blk2 = 1'b0, tblk = 1'b0, swap = 1'b0, noisy = 1'b0, lnk = 1'b0;
    logic [2:0] pa, pt;
    logic [15:0] tbl [9] = '{16'h0400, 16'h0470, 16'h0468, 16'h0478, 16'h0462, 16'h043e,
        16'h04a3, 16'h0527, 16'h0522};
    int n_fail = 0, checks_done = 0, seed = 17, cyc = 0;
    wire [19:0] obs = {ea, et, ec, ga, gt, pa, pt};
    pmtl_top #(.N(4), .DAY_CYCLES(DAY)) dut (.i_mclk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_fault(flt), .i_fault_l1(l1),
        .i_fault_l2(l2), .i_fault_l3(l3), .i_external_block_input_one(blk1),
        .i_external_block_input_two(blk2), .i_external_trip_block_input(tblk),
        .i_link_err(perr), .i_peer_pairing_code(pcode), .o_element_alarm(ea),
        .o_element_trip(et), .o_element_trip_command(ec), .o_general_alarm(ga),
        .o_general_trip(gt), .o_phase_collective_alarm(pa), .o_phase_collective_trip(pt),
        .o_link_active(la), .o_remote_access(ra), .o_link_quality_warning(qw), .o_irq(irq));
    pmtl_peer peer (.i_mclk(clk), .i_rst(rst), .i_code(code), .i_en(lnk), .i_swap(swap),
        .i_noisy(noisy), .o_code(pcode), .o_err(perr));
    // ----
    // Helpers
    // ----
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            n_fail += 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [19:0] expv(input logic [3:0] f, input logic cb);
        logic [3:0] u;
        logic [2:0] p;
        u = f & ~supv;
        p = {|(u & phc & l3), |(u & phc & l2), |(u & phc & l1)};
        return {f, f, cb ? 4'h0 : u, |u, |u, p, p};
    endfunction
    // ----
    // Scenarios
    // ----
    initial begin
        wt(12);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, ADDR_CTRL, 0);
        chk(rd, 32'h21);
        apb(0, ADDR_DLY0, 0);
        chk(rd, 32'h64);
        apb(0, ADDR_ERRMAX, 0);
        chk(rd, 32'h0a);
        apb(0, 8'h28, 0);
        chk({rd[30:0], serr}, 32'h1);
        apb(1, ADDR_ERRCNT, 32'h7);
        apb(0, ADDR_ERRCNT, 0);
        chk(rd, 32'h0);
        apb(1, ADDR_SUPV, 32'h8);
        apb(1, ADDR_PHCAP, 32'h3);
        for (int k = 0; k < 4; k++) apb(1, ADDR_DLY0 + 8'(4 * k), 32'h5);
        repeat (12) begin
            flt <= 4'($random(seed));
            l1 <= 4'($random(seed));
            l2 <= 4'($random(seed));
            l3 <= 4'($random(seed));
            wt(5);
            chk(32'({ea, et}), 32'({flt, 4'h0}));
            wt(8);
            chk(32'(obs), 32'(expv(flt, 1'b0)));
            flt <= 4'h0;
            wt(6);
        end
        flt <= 4'h1;
        wt(5);
        flt <= 4'h0;
        for (int k = 0; k < 12; k++) begin
            wt(1);
            chk(32'(et), 32'h0);
        end
        flt <= 4'hf;
        for (int k = 0; k < 9; k++) begin
            apb(1, ADDR_CTRL, 32'(tbl[k][12:5]));
            {blk1, blk2, tblk} <= tbl[k][4:2];
            wt(14);
            chk(32'(obs), tbl[k][1] ? 32'(expv(flt, tbl[k][0])) : 32'h0);
        end
        flt <= 4'h0;
        {blk1, blk2, tblk} <= 3'h0;
        apb(1, ADDR_PAIR, 32'h5a);
        apb(1, ADDR_CTRL, 32'h31);
        lnk <= 1'b1;
        wt(6);
        chk(32'({la, ra}), 32'h3);
        apb(1, ADDR_CTRL, 32'h11);
        wt(4);
        chk(32'({la, ra}), 32'h2);
        swap <= 1'b1;
        apb(0, ADDR_IRQ_ST, 0);
        wt(6);
        chk(32'({la, irq}), 32'h0);
        apb(1, ADDR_IRQ_MASK, 32'h8);
        wt(2);
        chk(32'(irq), 32'h1);
        apb(0, ADDR_IRQ_ST, 0);
        chk(rd & 32'h8, 32'h8);
        swap <= 1'b0;
        apb(1, ADDR_CTRL, 32'h01);
        lnk <= 1'b0;
        wt(6);
        chk(32'(la), 32'h0);
        apb(1, ADDR_ERRMAX, 32'h3);
        apb(1, ADDR_CTRL, 32'h31);
        lnk <= 1'b1;
        apb(1, ADDR_IRQ_MASK, 32'h4);
        wt(4);
        apb(0, ADDR_IRQ_ST, 0);
        noisy <= 1'b1;
        wt(6);
        noisy <= 1'b0;
        wt(6);
        chk(32'({qw, irq}), 32'h0);
        apb(0, ADDR_ERRCNT, 0);
        chk(rd, 32'h3);
        noisy <= 1'b1;
        wt(2);
        noisy <= 1'b0;
        wt(6);
        chk(32'({qw, irq}), 32'h3);
        apb(0, ADDR_IRQ_ST, 0);
        chk(rd, 32'h4);
        wt(2);
        chk(32'(irq), 32'h0);
        wt(DAY + 10);
        chk(32'(qw), 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
